// >>> src/ptimer_cfg_if.sv
/*
 * configuration bundle carried from the register file to the core.
 * assumes both ends share ref_clk.
 */
`timescale 1ns/10ps
interface ptimer_cfg_if;
    import ptimer_pkg::*;
    logic counter_on; // counter enable level
    logic clear_on_a; // one-cycle: single pulse ended, drop enable
    logic [1:0] operating_mode_select;
    logic [1:0] pin_function_select;
    logic output_level_control;
    logic output_invert;
    logic capture_source_select;
    logic clear_source_select;
    logic [9:0] compare_a_value;
    logic [9:0] period_compare_value;
    logic [9:0] count; // live counter
    logic capture_event; // one-cycle capture strobe
    modport regs (output counter_on, operating_mode_select,
        pin_function_select, output_level_control, output_invert,
        capture_source_select, clear_source_select, compare_a_value,
        period_compare_value, input count, clear_on_a, capture_event);
    modport core (input counter_on, operating_mode_select,
        pin_function_select, output_level_control, output_invert,
        capture_source_select, clear_source_select, compare_a_value,
        period_compare_value, output count, clear_on_a, capture_event);
endinterface // ptimer_cfg_if

// >>> src/ptimer_core.sv
/*
 * counter, comparators, output pin and capture edge logic.
 * assumes configuration is stable, counts one per ref_clk.
 */
`timescale 1ns/10ps
module ptimer_core
    import ptimer_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    ptimer_cfg_if.core cfg,
    input wire logic capture_input_pin,
    input wire logic external_clock_pin,
    output logic timer_output_pin
);
    logic [9:0] count_r;
    logic on_d_r; // previous enable level
    logic pin_r; // raw output state before inversion
    logic trig_d_r; // previous capture trigger level
    logic end_r;
    wire op_mode_t mode = op_mode_t'(cfg.operating_mode_select);
    wire on_rise = cfg.counter_on & ~on_d_r;
    wire match_a = cfg.counter_on & (count_r == cfg.compare_a_value);
    // a zero period value means a full 1024-count cycle, never a p match
    wire match_p = cfg.counter_on & (count_r == cfg.period_compare_value)
        & (cfg.period_compare_value != RST_VALUE); // R14
    // pwm period spans exactly period-value counts, 0 to value-1
    wire pwm_wrap = cfg.counter_on
        & ((count_r + 10'h001) == cfg.period_compare_value);
    wire overflow = cfg.counter_on & (count_r == COUNT_MAX);
    // clear source used only in compare and timer modes
    wire cmp_like = (mode == MODE_COMPARE) | (mode == MODE_TIMER); // R15
    wire clr_a = cmp_like & cfg.clear_source_select & match_a; // R13
    wire clr_p = (cmp_like & ~cfg.clear_source_select & match_p)
        | ((mode == MODE_PWM) & (cfg.pin_function_select != PF_3)
        & pwm_wrap); // R13
    // overflow clears only when period value is zero
    wire clr_ovf = ~clr_a & overflow
        & (cfg.period_compare_value == RST_VALUE); // R14
    wire trig = cfg.capture_source_select ? external_clock_pin
        : capture_input_pin; // R12
    wire t_rise = trig & ~trig_d_r;
    wire t_fall = ~trig & trig_d_r;
    logic cap_hit;
    logic pin_nxt;
    logic pwm_act;

    // capture edge selection
    always_comb begin
        unique case (cfg.pin_function_select)
            PF_0: cap_hit = t_rise; // R03
            PF_1: cap_hit = t_fall; // R03
            PF_2: cap_hit = t_rise | t_fall; // R03
            PF_3: cap_hit = 1'b0; // R03
        endcase
    end

    // duty active while count below compare a; a>=period gives 100%
    assign pwm_act = count_r < cfg.compare_a_value;

    // next raw pin level per mode
    always_comb begin
        pin_nxt = pin_r;
        if (on_rise) begin
            pin_nxt = cfg.output_level_control; // R05 R07 R09
        end else if (mode == MODE_COMPARE) begin
            if (match_a) begin
                unique case (cfg.pin_function_select)
                    PF_0: pin_nxt = pin_r; // R01
                    PF_1: pin_nxt = 1'b0; // R01 R04
                    PF_2: pin_nxt = 1'b1; // R01 R04
                    PF_3: pin_nxt = ~pin_r; // R01
                endcase
            end
        end else if (mode == MODE_PWM) begin
            unique case (cfg.pin_function_select)
                PF_0: pin_nxt = ~cfg.output_level_control; // R02 R08
                PF_1: pin_nxt = cfg.output_level_control; // R02 R08
                PF_2: pin_nxt = pwm_act ? cfg.output_level_control
                    : ~cfg.output_level_control; // R02 R08
                PF_3: pin_nxt = cfg.counter_on ? cfg.output_level_control
                    : ~cfg.output_level_control; // R02 R09
            endcase
        end
    end

    // single pulse ends on compare a match
    wire pulse_end = (mode == MODE_PWM) & (cfg.pin_function_select == PF_3)
        & match_a;
    assign cfg.clear_on_a = end_r;
    assign cfg.count = count_r;
    assign cfg.capture_event = (mode == MODE_CAPTURE) & cap_hit;

    // counter: reset on enable rise, freeze while off
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= RST_VALUE;
        end else if (on_rise) begin
            count_r <= RST_VALUE; // R22
        end else if (cfg.counter_on & ~end_r) begin
            count_r <= (clr_a | clr_p | clr_ovf) ? RST_VALUE
                : count_r + 10'h001; // R13
        end
    end

    // edge history and pulse end strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            on_d_r <= 1'b0;
            trig_d_r <= 1'b0;
            end_r <= 1'b0;
        end else begin
            on_d_r <= cfg.counter_on;
            trig_d_r <= trig;
            end_r <= pulse_end & ~end_r;
        end
    end

    // output pin; invert and level unused in timer mode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_r <= 1'b0;
            timer_output_pin <= 1'b0;
        end else begin
            pin_r <= pin_nxt;
            timer_output_pin <= (mode == MODE_TIMER) ? 1'b0
                : (pin_nxt ^ cfg.output_invert); // R10 R11
        end
    end
endmodule // ptimer_core

// >>> src/ptimer_pkg.sv
/*
 * shared constants for the periodic 10-bit timer: register offsets,
 * control field positions, reset values and mode encodings.
 * assumes a 32-bit apb slave with one register per aligned word.
 */
package ptimer_pkg;

    // byte addresses of the registers on apb
    localparam logic [7:0] OFF_CONTROL_ZERO = 8'h00;
    localparam logic [7:0] OFF_CONTROL_ONE = 8'h04;
    localparam logic [7:0] OFF_COUNT_LOW = 8'h08;
    localparam logic [7:0] OFF_COUNT_HIGH = 8'h0C;
    localparam logic [7:0] OFF_CMPA_LOW = 8'h10;
    localparam logic [7:0] OFF_CMPA_HIGH = 8'h14;
    localparam logic [7:0] OFF_PERIOD_LOW = 8'h18;
    localparam logic [7:0] OFF_PERIOD_HIGH = 8'h1C;

    // control zero: counter enable bit position
    localparam int BIT_COUNTER_ON = 3;
    // control one field positions
    localparam int POS_MODE = 6;
    localparam int POS_PIN_FUNC = 4;
    localparam int BIT_OUT_LEVEL = 3;
    localparam int BIT_OUT_INVERT = 2;
    localparam int BIT_CAP_SOURCE = 1;
    localparam int BIT_CLEAR_SOURCE = 0;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [9:0] RST_VALUE = 10'h000;
    localparam logic [9:0] COUNT_MAX = 10'h3FF;

    // operating modes
    typedef enum logic [1:0] {
        MODE_COMPARE = 2'h0,
        MODE_CAPTURE = 2'h1,
        MODE_PWM = 2'h2,
        MODE_TIMER = 2'h3
    } op_mode_t;

    // pin function codes
    localparam logic [1:0] PF_0 = 2'h0;
    localparam logic [1:0] PF_1 = 2'h1;
    localparam logic [1:0] PF_2 = 2'h2;
    localparam logic [1:0] PF_3 = 2'h3;

    // low byte of a ten-bit value
    function automatic logic [7:0] low_byte(input logic [9:0] v);
        return v[7:0];
    endfunction

    // high byte with unused bits zero
    function automatic logic [7:0] high_byte(input logic [9:0] v);
        return {6'h00, v[9:8]};
    endfunction

endpackage

// >>> src/ptimer_top.sv
/*
 * periodic 10-bit timer with apb register file.
 * assumes a single 50 mhz ref_clk, apb master on the same clock,
 * and software that changes pin function only with the timer off.
 */
// Notes on behaviour
// R01: compare mode: match a acts per pin function
// R02: pwm mode: inactive, active, pwm, single pulse
// R03: capture mode: rising, falling, both, disabled
// R04: requested level equal initial gives no change
// R05: enable rise restores initial level
// R06: software changes pin function only when off
// R07: compare mode: level bit sets initial level
// R08: pwm mode: level bit sets active level
// R09: single pulse: level bit applied on start
// R10: level and invert unused in timer mode
// R11: invert bit inverts output pin
// R12: capture source: capture pin or clock pin
// R13: clear on match a, else match p/overflow
// R14: overflow clear only with zero period value
// R15: clear source ignored in pwm, pulse, capture
// R16: counter readable as read-only byte pair
// R17: compare a held as read/write pair
// R18: period value held as read/write pair
// R19: high byte bits 7 to 2 read zero
// R20: mode field selects compare, capture, pwm, timer
// R21: low bytes move via buffer on high access
// R22: enable rise zeroes counter, fall freezes it
`timescale 1ns/10ps
module ptimer_top
    import ptimer_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_input_pin,
    input wire logic external_clock_pin,
    output logic timer_output_pin,
    output logic timer_output_oe,
    output logic capture_pulse
);
    logic rst_s1_r; // reset synchroniser stages
    logic rst_n; // synchronised reset
    logic [7:0] ctl0_r; // enable register
    logic [7:0] timer_control_one_r; // mode and pin configuration
    logic [9:0] cmpa_r; // compare a value
    logic [9:0] period_r; // period compare value
    logic [7:0] buf_r; // shared low byte buffer
    logic [31:0] rdata_nxt;
    logic core_pin;
    ptimer_cfg_if cfg ();

    // async assert, sync release of reset
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // apb decode: access phase, answer in the first access cycle
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire rd = access & ~pwrite;
    wire [7:0] a = paddr[7:0];
    wire hit = (paddr[31:8] == 24'h000000) & (a[1:0] == 2'h0)
        & (a <= OFF_PERIOD_HIGH);
    wire [7:0] wb = pwdata[7:0];

    // read mux; high-byte reads return the live high bits
    always_comb begin
        rdata_nxt = 32'h00000000;
        unique case (a)
            OFF_CONTROL_ZERO: rdata_nxt[7:0] = ctl0_r;
            OFF_CONTROL_ONE: rdata_nxt[7:0] = timer_control_one_r;
            OFF_COUNT_HIGH: rdata_nxt[7:0] = high_byte(cfg.count); // R16 R19
            OFF_CMPA_HIGH: rdata_nxt[7:0] = high_byte(cmpa_r); // R17 R19
            OFF_PERIOD_HIGH: rdata_nxt[7:0] = high_byte(period_r); // R18 R19
            OFF_COUNT_LOW, OFF_CMPA_LOW, OFF_PERIOD_LOW:
                rdata_nxt[7:0] = buf_r; // R21
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    // apb answer registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable; // ready on first access cycle
            pslverr <= psel & ~penable & ~hit;
            prdata <= (psel & ~penable & ~pwrite & hit) ? rdata_nxt
                : 32'h00000000;
        end
    end

    // transfer completes when access seen with pready high
    wire done = access & pready & hit;

    // control registers; single pulse end clears enable
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl0_r <= RST_BYTE;
            timer_control_one_r <= RST_BYTE;
        end else begin
            if (done & pwrite & (a == OFF_CONTROL_ZERO)) begin
                ctl0_r <= wb & 8'hF8; // low bits unimplemented
            end
            // pulse end clear comes last so hardware beats a write
            if (cfg.clear_on_a) begin
                ctl0_r[BIT_COUNTER_ON] <= 1'b0;
            end
            if (done & pwrite & (a == OFF_CONTROL_ONE)) begin
                timer_control_one_r <= wb; // R06
            end
        end
    end

    // compare pairs and shared buffer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmpa_r <= RST_VALUE;
            period_r <= RST_VALUE;
            buf_r <= RST_BYTE;
        end else if (done) begin
            unique case (a)
                OFF_CMPA_LOW, OFF_PERIOD_LOW:
                    if (pwrite) buf_r <= wb; // R21
                OFF_CMPA_HIGH:
                    if (pwrite) cmpa_r <= {wb[1:0], buf_r}; // R17 R21
                    else buf_r <= low_byte(cmpa_r); // R21
                OFF_PERIOD_HIGH:
                    if (pwrite) period_r <= {wb[1:0], buf_r}; // R18 R21
                    else buf_r <= low_byte(period_r); // R21
                OFF_COUNT_HIGH:
                    if (!pwrite) buf_r <= low_byte(cfg.count); // R16 R21
                default: buf_r <= buf_r;
            endcase
        end
    end

    // configuration out to the core
    assign cfg.counter_on = ctl0_r[BIT_COUNTER_ON];
    assign cfg.operating_mode_select =
        timer_control_one_r[POS_MODE +: 2]; // R20
    assign cfg.pin_function_select = timer_control_one_r[POS_PIN_FUNC +: 2];
    assign cfg.output_level_control = timer_control_one_r[BIT_OUT_LEVEL];
    assign cfg.output_invert = timer_control_one_r[BIT_OUT_INVERT];
    assign cfg.capture_source_select = timer_control_one_r[BIT_CAP_SOURCE];
    assign cfg.clear_source_select = timer_control_one_r[BIT_CLEAR_SOURCE];
    assign cfg.compare_a_value = cmpa_r;
    assign cfg.period_compare_value = period_r;

    ptimer_core u_core (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .cfg(cfg),
        .capture_input_pin(capture_input_pin),
        .external_clock_pin(external_clock_pin),
        .timer_output_pin(core_pin)
    );

    // pin outputs; pin unused in capture and timer modes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_output_pin <= 1'b0;
            timer_output_oe <= 1'b0;
            capture_pulse <= 1'b0;
        end else begin
            timer_output_pin <= core_pin;
            timer_output_oe <= ~timer_control_one_r[POS_MODE]; // R20
            capture_pulse <= cfg.capture_event;
        end
    end
endmodule // ptimer_top

// >>> tb/periodic_timer_pin_config_tb.sv
/* self-checking bench for the timer: apb tasks and mode scenarios.
   assumes ptimer_top with apb answer one cycle after setup. */
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
    miscompares++; $display("mismatch at %0t: got %h exp %h", \
    $time, g, e); end end
module periodic_timer_pin_config_tb;
    import ptimer_pkg::*;
    logic ref_clk, reset_n, psel, penable, pwrite, cap_pin, ext_pin;
    logic [31:0] paddr, pwdata, prdata, rv;
    logic pready, pslverr, pin, oe, cpulse, er, lv, iv, ex;
    logic [1:0] pf;
    logic [7:0] a;
    logic [9:0] cv, c1;
    int miscompares = 0, checks_done = 0, pulses = 0, cycles = 0, n, p0;
    ptimer_top ptimer_top_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_input_pin(cap_pin),
        .external_clock_pin(ext_pin), .timer_output_pin(pin),
        .timer_output_oe(oe), .capture_pulse(cpulse));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // pulse tally and hang guard, sized well above the planned run
    always @(posedge ref_clk) begin
        if (cpulse === 1'b1) pulses <= pulses + 1;
        cycles <= cycles + 1;
        if (cycles > 30000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    // one apb transfer; holds the request until pready is sampled
    task automatic xf(input logic w, input logic [7:0] ad, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, ad};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    // pairs go low byte first on write, high byte first on read
    task automatic setv(input logic [7:0] lo, input logic [9:0] v);
        xf(1'b1, lo, {24'h0, v[7:0]});
        xf(1'b1, lo + 8'h04, {30'h0, v[9:8]});
    endtask
    task automatic getv(input logic [7:0] lo);
        xf(1'b0, lo + 8'h04, 32'h0);
        cv[9:8] = rv[1:0];
        xf(1'b0, lo, 32'h0);
        cv[7:0] = rv[7:0];
    endtask
    // pin function only changes with the timer off
    task automatic start(input logic [7:0] c);
        xf(1'b1, OFF_CONTROL_ZERO, 32'h0);
        xf(1'b1, OFF_CONTROL_ONE, {24'h0, c});
        xf(1'b1, OFF_CONTROL_ZERO, 32'h8);
    endtask
    initial begin
        {psel, penable, pwrite, cap_pin, ext_pin} = 5'h00;
        paddr = 32'h0;
        pwdata = 32'h0;
        reset_n = 1'b0;
        cyc(8);
        reset_n <= 1'b1;
        cyc(4);
        for (int k = 0; k < 32; k += 4) begin
            xf(1'b0, k[7:0], 32'h0);
            `CHK(rv, 32'h0)
        end
        xf(1'b0, 8'h20, 32'h0);
        `CHK(er, 1'b1)
        for (int k = 0; k < 2; k++) begin
            a = k ? OFF_PERIOD_LOW : OFF_CMPA_LOW;
            xf(1'b1, a, 32'hA5);
            xf(1'b0, a + 8'h04, 32'h0);
            xf(1'b0, a, 32'h0);
            `CHK(rv, 32'h0)
            xf(1'b1, a, 32'hA5);
            xf(1'b1, a + 8'h04, 32'hFE);
            getv(a);
            `CHK(cv, 10'h2A5)
            `CHK(rv, 32'hA5)
        end
        // compare output: every pin function, level and inversion
        setv(OFF_PERIOD_LOW, 10'h0);
        setv(OFF_CMPA_LOW, 10'd100);
        for (int k = 0; k < 16; k++) begin
            pf = k[3:2];
            lv = k[1];
            iv = k[0];
            start({MODE_COMPARE, pf, lv, iv, 2'b00});
            cyc(4);
            `CHK(pin, lv ^ iv)
            `CHK(oe, 1'b1)
            cyc(150);
            ex = (pf == PF_0) ? lv : (pf == PF_1) ? 1'b0 :
                (pf == PF_2) ? 1'b1 : ~lv;
            `CHK(pin, ex ^ iv)
            xf(1'b1, OFF_CONTROL_ZERO, 32'h0);
            xf(1'b1, OFF_CONTROL_ZERO, 32'h8);
            cyc(4);
            `CHK(pin, lv ^ iv)
        end
        // pwm: duty 10 of period 40, clear source set but ignored
        setv(OFF_CMPA_LOW, 10'd10);
        setv(OFF_PERIOD_LOW, 10'd40);
        for (int k = 0; k < 12; k++) begin
            pf = k[3:2];
            lv = k[1];
            iv = k[0];
            start({MODE_PWM, pf, lv, iv, 2'b01});
            cyc(4);
            n = 0;
            repeat (80) begin
                @(posedge ref_clk);
                n += (pin === (lv ^ iv));
            end
            ex = (pf == PF_2) ? (n >= 19 && n <= 21)
                : (n == ((pf == PF_1) ? 80 : 0));
            `CHK(ex, 1'b1)
        end
        // single pulse ends at match a and drops the enable bit
        setv(OFF_CMPA_LOW, 10'd30);
        for (int k = 0; k < 2; k++) begin
            lv = k[0];
            start({MODE_PWM, PF_3, lv, 3'b000});
            cyc(4);
            `CHK(pin, lv)
            cyc(60);
            `CHK(pin, ~lv)
            xf(1'b0, OFF_CONTROL_ZERO, 32'h0);
            `CHK(rv[3], 1'b0)
        end
        // capture: each edge choice from each source, other pin ignored
        for (int k = 0; k < 8; k++) begin
            pf = k[2:1];
            iv = k[0];
            start({MODE_CAPTURE, pf, 2'b00, iv, 1'b0});
            p0 = pulses;
            for (int s = 0; s < 4; s++) begin
                if (iv ^ s[0]) ext_pin <= ~s[1];
                else cap_pin <= ~s[1];
                cyc(6);
            end
            n = (pf == PF_3) ? 0 : (pf == PF_2) ? 2 : 1;
            `CHK(pulses - p0, n)
            `CHK(oe, 1'b0)
        end
        // timer mode: clear source bounds the count, pin unused
        setv(OFF_CMPA_LOW, 10'd20);
        setv(OFF_PERIOD_LOW, 10'd30);
        for (int k = 0; k < 2; k++) begin
            start({MODE_TIMER, PF_3, 3'b110, k[0]});
            `CHK(pin, 1'b0)
            repeat (6) begin
                getv(OFF_COUNT_LOW);
                `CHK(cv <= (k ? 10'd20 : 10'd30), 1'b1)
            end
        end
        setv(OFF_PERIOD_LOW, 10'h0);
        start({MODE_TIMER, 6'h00});
        cyc(600);
        xf(1'b1, OFF_CONTROL_ZERO, 32'h0);
        getv(OFF_COUNT_LOW);
        c1 = cv;
        `CHK(cv > 10'd500, 1'b1)
        xf(1'b1, OFF_COUNT_HIGH, 32'h3);
        cyc(20);
        getv(OFF_COUNT_LOW);
        `CHK(cv, c1)
        xf(1'b1, OFF_CONTROL_ZERO, 32'h8);
        getv(OFF_COUNT_LOW);
        `CHK(cv < 10'd30, 1'b1)
        report_and_stop();
    end
endmodule // periodic_timer_pin_config_tb

// >>> tb/ptimer_top_asserts.sv
/* checker for the timer top: apb handshake, refusals, read data, capture.
   assumes the ports of ptimer_top, one clock, reset_n active low. */
`timescale 1ns/10ps
module ptimer_top_checker
    import ptimer_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timer_output_oe,
    input wire logic capture_pulse
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // read answer from one of the three high-byte places
    wire rd_hi = pready && !pwrite && (paddr == {24'h0, OFF_COUNT_HIGH}
        || paddr == {24'h0, OFF_CMPA_HIGH}
        || paddr == {24'h0, OFF_PERIOD_HIGH});
    a_ready_after_setup:
        assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_only_access:
        assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_ready_one_cycle:
        assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_refuse_unmapped:
        assert property (psel && !penable && paddr >= 32'h20
            |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_accept_mapped:
        assert property (psel && !penable && paddr < 32'h20
            && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("mapped access refused");
    a_high_bits_zero:
        assert property (rd_hi |-> prdata[31:2] == 30'h0)
        else $error("high byte upper bits set");
    a_ctrl_low_zero:
        assert property (pready && !pwrite && paddr == 32'h0
            |-> prdata[2:0] == 3'h0)
        else $error("control zero low bits set");
    a_capture_no_oe:
        assert property (capture_pulse |-> !timer_output_oe)
        else $error("capture while pin driven");
    a_capture_single:
        assert property (capture_pulse |=> !capture_pulse)
        else $error("capture pulse too long");
endmodule // ptimer_top_checker
bind ptimer_top ptimer_top_checker ptimer_top_checker_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_output_oe(timer_output_oe), .capture_pulse(capture_pulse));
